// [shared/gsdp_pkg.sv]
// Package: register map, fields, reset values and timing of the gyro status/data/power bank
package gsdp_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h1a;
	localparam logic [7:0] OFS_TEMP_HIGH = 8'h1b;
	localparam logic [7:0] OFS_TEMP_LOW = 8'h1c;
	localparam logic [7:0] OFS_RATE_X_HIGH = 8'h1d;
	localparam logic [7:0] OFS_RATE_X_LOW = 8'h1e;
	localparam logic [7:0] OFS_RATE_Y_HIGH = 8'h1f;
	localparam logic [7:0] OFS_RATE_Y_LOW = 8'h20;
	localparam logic [7:0] OFS_RATE_Z_HIGH = 8'h21;
	localparam logic [7:0] OFS_RATE_Z_LOW = 8'h22;
	localparam logic [7:0] OFS_POWER_CONTROL = 8'h3e;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_PLL_LOCKED_FLAG = 2;
	localparam int BIT_DATA_READY_FLAG = 0;
	localparam int BIT_MASTER_RESET = 7;
	localparam int BIT_SLEEP = 6;
	localparam int BIT_X_AXIS_STANDBY = 5;
	localparam int BIT_Y_AXIS_STANDBY = 4;
	localparam int BIT_Z_AXIS_STANDBY = 3;
	localparam int CLK_SEL_LSB = 0;
	localparam logic [7:0] STATUS_USED_MASK = 8'h05;
	localparam logic [7:0] POWER_USED_MASK = 8'h7f;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
	localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
	localparam logic [7:0] RST_DIVIDER = 8'h00;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_FREQ_HZ = 200000000;
	localparam int INTERNAL_RATE_HZ = 1000;
	localparam int INTERNAL_TICK_CYCLES = CLK_FREQ_HZ / INTERNAL_RATE_HZ;
	localparam int PLL_LOCK_TIME_US = 10;
	localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_US * (CLK_FREQ_HZ / 1000000));
	// ----------------------------------------
	// Clock source selection
	// ----------------------------------------
	typedef enum logic [2:0] {
		GSDP_CLK_INTERNAL = 3'h0,
		GSDP_CLK_PLL_X = 3'h1,
		GSDP_CLK_PLL_Y = 3'h2,
		GSDP_CLK_PLL_Z = 3'h3,
		GSDP_CLK_PLL_EXT32K = 3'h4,
		GSDP_CLK_PLL_EXT19M = 3'h5,
		GSDP_CLK_RSVD6 = 3'h6,
		GSDP_CLK_RSVD7 = 3'h7
	} gsdp_clk_sel_t;
endpackage

// [hdl/gsdp_tick_divider.sv]
// Module: divider that turns mclk into a one-cycle enable every PERIOD cycles
`timescale 1ns/1ps
module gsdp_tick_divider #(
	parameter int PERIOD = 200000
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic run,
	output logic tick
);
	logic [31:0] count_r;

	always_ff @(posedge mclk) begin
		if (reset || !run) begin
			count_r <= 32'h0;
			tick <= 1'b0;
		end else if (count_r == 32'(PERIOD - 1)) begin
			count_r <= 32'h0;
			tick <= 1'b1;
		end else begin
			count_r <= count_r + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule

// [hdl/gsdp_regs.sv]
// Module: status, sensor result and power-management registers of the gyro
`timescale 1ns/1ps
module gsdp_regs #(
	parameter int TICK_CYCLES = gsdp_pkg::INTERNAL_TICK_CYCLES,
	parameter int LOCK_CYCLES = gsdp_pkg::PLL_LOCK_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic [7:0] sampleDivider,
	input wire logic pllLockedIrqEnable,
	input wire logic dataReadyIrqEnable,
	input wire logic statusClearOnAnyRead,
	input wire logic [15:0] tempSample,
	input wire logic [15:0] rateXSample,
	input wire logic [15:0] rateYSample,
	input wire logic [15:0] rateZSample,
	output logic masterResetPulse,
	output logic sleepMode,
	output logic xAxisStandby,
	output logic yAxisStandby,
	output logic zAxisStandby,
	output logic [2:0] clockSelect,
	output logic pllLocked
);
	import gsdp_pkg::*;

	// ----------------------------------------
	// Internal state
	// ----------------------------------------
	logic [7:0] power_r;
	logic [7:0] status_r;
	logic [7:0] div_r;
	logic [15:0] temp_r;
	logic [15:0] rateX_r;
	logic [15:0] rateY_r;
	logic [15:0] rateZ_r;
	logic [31:0] lockCount_r;
	logic lockDone_r;
	logic [2:0] lastClk_r;
	logic devReset;
	logic tick;
	logic resultLoad;
	logic lockEvent;
	logic readClear;
	logic [7:0] powerWdata;

	// Master reset also clears every register except this bank's bus side
	assign devReset = reset || masterResetPulse;
	assign powerWdata = regWdata & POWER_USED_MASK;

	// ----------------------------------------
	// Power management
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (devReset) begin
			power_r <= RST_POWER_CONTROL;
		end else if (regWrite && regAddr == OFS_POWER_CONTROL) begin
			power_r <= powerWdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			masterResetPulse <= 1'b0;
		end else begin
			masterResetPulse <= regWrite && regAddr == OFS_POWER_CONTROL
				&& regWdata[BIT_MASTER_RESET];
		end
	end

	assign sleepMode = power_r[BIT_SLEEP];
	assign xAxisStandby = power_r[BIT_X_AXIS_STANDBY];
	assign yAxisStandby = power_r[BIT_Y_AXIS_STANDBY];
	assign zAxisStandby = power_r[BIT_Z_AXIS_STANDBY];
	assign clockSelect = power_r[CLK_SEL_LSB +: 3];

	// ----------------------------------------
	// PLL lock tracking
	// ----------------------------------------
	// Lock restarts on every change of clock source; oscillator and reserved codes never lock
	always_ff @(posedge mclk) begin
		if (devReset) begin
			lastClk_r <= 3'h0;
			lockCount_r <= 32'h0;
			lockDone_r <= 1'b0;
		end else begin
			lastClk_r <= clockSelect;
			if (clockSelect != lastClk_r || sleepMode) begin
				lockCount_r <= 32'h0;
				lockDone_r <= 1'b0;
			end else if (clockSelect == GSDP_CLK_INTERNAL
				|| clockSelect == GSDP_CLK_RSVD6 || clockSelect == GSDP_CLK_RSVD7) begin
				lockCount_r <= 32'h0;
				lockDone_r <= 1'b0;
			end else if (!lockDone_r) begin
				if (lockCount_r == 32'(LOCK_CYCLES - 1)) begin
					lockDone_r <= 1'b1;
				end
				lockCount_r <= lockCount_r + 32'h1;
			end
		end
	end

	assign pllLocked = lockDone_r;
	assign lockEvent = lockDone_r == 1'b0 && !devReset && !sleepMode
		&& lockCount_r == 32'(LOCK_CYCLES - 1) && clockSelect == lastClk_r
		&& clockSelect != GSDP_CLK_INTERNAL && clockSelect != GSDP_CLK_RSVD6
		&& clockSelect != GSDP_CLK_RSVD7;

	// ----------------------------------------
	// Sampling
	// ----------------------------------------
	gsdp_tick_divider #(
		.PERIOD(TICK_CYCLES)
	) u_tick (
		.mclk(mclk),
		.reset(devReset),
		.run(!sleepMode),
		.tick(tick)
	);

	always_ff @(posedge mclk) begin
		if (devReset) begin
			div_r <= RST_DIVIDER;
		end else if (tick && !sleepMode) begin
			div_r <= (div_r >= sampleDivider) ? 8'h00 : div_r + 8'h01;
		end
	end

	// A tick already in flight when sleep starts must not load
	assign resultLoad = tick && !sleepMode && div_r >= sampleDivider;

	// Axes in standby hold their last result
	always_ff @(posedge mclk) begin
		if (devReset) begin
			temp_r <= 16'h0;
			rateX_r <= 16'h0;
			rateY_r <= 16'h0;
			rateZ_r <= 16'h0;
		end else if (resultLoad) begin
			temp_r <= tempSample;
			if (!xAxisStandby) begin
				rateX_r <= rateXSample;
			end
			if (!yAxisStandby) begin
				rateY_r <= rateYSample;
			end
			if (!zAxisStandby) begin
				rateZ_r <= rateZSample;
			end
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	assign readClear = regRead && (statusClearOnAnyRead || regAddr == OFS_IRQ_STATUS);

	// Set wins over a clear in the same cycle; pin polarity and latch mode never reach here
	always_ff @(posedge mclk) begin
		if (devReset) begin
			status_r <= RST_IRQ_STATUS;
		end else begin
			if (readClear) begin
				status_r <= RST_IRQ_STATUS;
			end
			if (resultLoad && dataReadyIrqEnable) begin
				status_r[BIT_DATA_READY_FLAG] <= 1'b1;
			end
			if (lockEvent && pllLockedIrqEnable) begin
				status_r[BIT_PLL_LOCKED_FLAG] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			regRdata <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				OFS_IRQ_STATUS: regRdata <= status_r & STATUS_USED_MASK;
				OFS_TEMP_HIGH: regRdata <= temp_r[15:8];
				OFS_TEMP_LOW: regRdata <= temp_r[7:0];
				OFS_RATE_X_HIGH: regRdata <= rateX_r[15:8];
				OFS_RATE_X_LOW: regRdata <= rateX_r[7:0];
				OFS_RATE_Y_HIGH: regRdata <= rateY_r[15:8];
				OFS_RATE_Y_LOW: regRdata <= rateY_r[7:0];
				OFS_RATE_Z_HIGH: regRdata <= rateZ_r[15:8];
				OFS_RATE_Z_LOW: regRdata <= rateZ_r[7:0];
				OFS_POWER_CONTROL: regRdata <= power_r & POWER_USED_MASK;
				default: regRdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	status_reset_a: assert property (@(posedge mclk) disable iff (reset)
		$rose(masterResetPulse) |=> status_r == 8'h00)
		else $error("status not cleared by master reset");
	data_ready_set_a: assert property (@(posedge mclk) disable iff (devReset)
		resultLoad && dataReadyIrqEnable |=> status_r[0])
		else $error("data ready flag not set on result load");
	gate_off_a: assert property (@(posedge mclk) disable iff (devReset)
		!dataReadyIrqEnable && !status_r[0] && !readClear |=> !status_r[0])
		else $error("data ready set while disabled");
	status_clear_a: assert property (@(posedge mclk) disable iff (devReset)
		regRead && regAddr == OFS_IRQ_STATUS && !resultLoad && !lockEvent |=> status_r == 8'h00)
		else $error("status read did not clear");
	any_read_a: assert property (@(posedge mclk) disable iff (devReset)
		regRead && !statusClearOnAnyRead && regAddr != OFS_IRQ_STATUS
		|=> (status_r & $past(status_r)) == $past(status_r))
		else $error("non-status read cleared status");
	unused_zero_a: assert property (@(posedge mclk) disable iff (reset)
		status_r[7:3] == 5'h0 && status_r[1] == 1'b0 && power_r[7] == 1'b0)
		else $error("undefined bit set");
	hres_pulse_a: assert property (@(posedge mclk) disable iff (reset)
		masterResetPulse |=> !masterResetPulse ##0 power_r == 8'h00)
		else $error("master reset did not clear power register");
	sleep_freeze_a: assert property (@(posedge mclk) disable iff (devReset)
		sleepMode |=> !tick)
		else $error("sampling runs in sleep");
	standby_hold_a: assert property (@(posedge mclk) disable iff (devReset)
		xAxisStandby && !$past(devReset) |=> rateX_r == $past(rateX_r) || !$past(xAxisStandby))
		else $error("standby axis updated");
	read_temp_a: assert property (@(posedge mclk) disable iff (reset)
		regRead && regAddr == OFS_TEMP_HIGH |=> regRdata == $past(temp_r[15:8]))
		else $error("temperature high byte wrong");
endmodule

// [testbench/gsdp_host_model.sv]
// Host model: single-byte register accesses over the strobe bus
`timescale 1ns/1ps
module gsdp_host_model (
	input wire logic mclk,
	output logic [7:0] regAddr,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regWdata,
	input wire logic [7:0] regRdata
);
	initial begin
		regAddr = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWdata = 8'h00;
	end
	// Released lines show the inverse so stale values never look valid
	task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge mclk);
		regAddr = addr;
		regWdata = data;
		regWrite = 1'b1;
		@(negedge mclk);
		regWrite = 1'b0;
		regWdata = ~data;
		regAddr = ~addr;
	endtask
	task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge mclk);
		regAddr = addr;
		regRead = 1'b1;
		@(negedge mclk);
		regRead = 1'b0;
		regAddr = ~addr;
		data = regRdata;
	endtask
endmodule

// [testbench/gyro_status_data_power_regs_tb.sv]
// Testbench: register sequences against the gyro status/data/power bank
`timescale 1ns/1ps
module gyro_status_data_power_regs_tb;
	import gsdp_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] regAddr, regWdata, regRdata, sampleDivider = 8'h07;
	logic regWrite, regRead;
	logic pllEn = 1'b1;
	logic rdyEn = 1'b0;
	logic anyRd = 1'b0;
	logic [15:0] smp [4] = '{16'h8123, 16'h1234, 16'hfe56, 16'h7f9a};
	logic masterResetPulse, sleepMode, xSb, ySb, zSb, pllLocked;
	logic [2:0] clockSelect;
	logic [7:0] d;
	int failures = 0;
	int checksDone = 0;
	always #2.5 mclk = ~mclk;
	gsdp_host_model host_u (.mclk(mclk), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));
	gsdp_regs #(.TICK_CYCLES(20), .LOCK_CYCLES(8)) dut_u (.mclk(mclk), .reset(reset),
		.regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
		.regRdata(regRdata), .sampleDivider(sampleDivider), .pllLockedIrqEnable(pllEn),
		.dataReadyIrqEnable(rdyEn), .statusClearOnAnyRead(anyRd), .tempSample(smp[0]),
		.rateXSample(smp[1]), .rateYSample(smp[2]), .rateZSample(smp[3]),
		.masterResetPulse(masterResetPulse), .sleepMode(sleepMode), .xAxisStandby(xSb),
		.yAxisStandby(ySb), .zAxisStandby(zSb), .clockSelect(clockSelect),
		.pllLocked(pllLocked));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic expectReg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		host_u.readReg(a, v);
		check({a, v}, {a, e});
	endtask
	task automatic stop_test();
		if (failures == 0 && checksDone > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		stop_test();
	end
	initial begin
		idle(20);
		reset = 1'b0;
		expectReg(OFS_IRQ_STATUS, 8'h00);
		expectReg(OFS_POWER_CONTROL, 8'h00);
		check(clockSelect, 16'h0000);
		// Unused axes to standby, external PLL source
		host_u.writeReg(OFS_POWER_CONTROL, 8'h3d);
		check({sleepMode, xSb, ySb, zSb, clockSelect}, {4'b0111, 3'h5});
		expectReg(OFS_POWER_CONTROL, 8'h3d);
		idle(20);
		check(pllLocked, 16'h0001);
		expectReg(OFS_IRQ_STATUS, 8'h04);
		expectReg(OFS_IRQ_STATUS, 8'h00);
		host_u.writeReg(OFS_POWER_CONTROL, 8'h01);
		rdyEn = 1'b1;
		// Sync to a result load through the data-ready flag
		d = 8'h00;
		for (int i = 0; i < 400 && d[0] !== 1'b1; i++) begin
			host_u.readReg(OFS_IRQ_STATUS, d);
		end
		check(d[0], 16'h0001);
		for (int i = 0; i < 8; i++) begin
			expectReg(OFS_TEMP_HIGH + 8'(i), i[0] ? smp[i/2][7:0] : smp[i/2][15:8]);
		end
		anyRd = 1'b1;
		idle(150);
		expectReg(OFS_TEMP_LOW, smp[0][7:0]);
		expectReg(OFS_IRQ_STATUS, 8'h00);
		anyRd = 1'b0;
		idle(160);
		expectReg(OFS_TEMP_HIGH, smp[0][15:8]);
		expectReg(OFS_IRQ_STATUS, 8'h01);
		rdyEn = 1'b0;
		expectReg(OFS_IRQ_STATUS, 8'h00);
		idle(200);
		expectReg(OFS_IRQ_STATUS, 8'h00);
		// Sleep freezes the results while registers stay reachable
		host_u.writeReg(OFS_POWER_CONTROL, 8'h41);
		check(sleepMode, 16'h0001);
		smp[0] = 16'h0102;
		idle(200);
		expectReg(OFS_TEMP_HIGH, 8'h81);
		expectReg(OFS_POWER_CONTROL, 8'h41);
		host_u.writeReg(OFS_POWER_CONTROL, 8'h80);
		check(masterResetPulse, 16'h0001);
		idle(3);
		check(masterResetPulse, 16'h0000);
		check({pllLocked, clockSelect}, 16'h0000);
		expectReg(OFS_POWER_CONTROL, 8'h00);
		expectReg(OFS_TEMP_HIGH, 8'h00);
		host_u.writeReg(OFS_IRQ_STATUS, 8'hff);
		expectReg(OFS_IRQ_STATUS, 8'h00);
		expectReg(8'h00, 8'h00);
		stop_test();
	end
endmodule
